//--- rtl/asp_pkg.sv
package asp_pkg;

	// serial word length shared by the control and data registers
	localparam int WORD_W = 24;

	// rate of clk, and the self-clocking divider built from it
	localparam int CLK_HZ      = 20_000_000;
	localparam int SCLK_DIV    = 4;
	localparam int SCLK_HI     = 1;
	localparam int SCLK_OUT_HZ = CLK_HZ / SCLK_DIV;

	// an external serial clock may run at most at clk / this figure
	localparam int SCLK_EXT_MAX_DIV = 5;

	// reset values
	localparam logic [WORD_W-1:0] CTRL_RST = 24'h000000;
	localparam logic [WORD_W-1:0] DATA_RST = 24'h000000;

	// synchroniser lane order: mode, rx strobe, tx strobe, read toggle, write toggle
	localparam int               SYNC_W   = 5;
	localparam logic [SYNC_W-1:0] SYNC_RST = 5'h0C;

	typedef enum logic [1:0] {
		GEN_IDLE,
		GEN_RUN,
		GEN_DONE
	} asp_gen_state_t;

endpackage

//--- rtl/asp_serial_port.sv
module asp_serial_port #(
	parameter int WORD_W   = asp_pkg::WORD_W,
	parameter int SCLK_DIV = asp_pkg::SCLK_DIV,
	parameter int SCLK_HI  = asp_pkg::SCLK_HI
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              clock_mode_self,
	input  wire logic              receive_frame_strobe_n,
	input  wire logic              transmit_frame_strobe_n,
	input  wire logic              register_select,
	input  wire logic              sclk_i,
	output logic                   sclk_o,
	output logic                   sclk_oe,
	input  wire logic              data_in,
	output logic                   data_out,
	output logic                   data_out_oe,
	input  wire logic [WORD_W-1:0] conv_word,
	input  wire logic              conv_valid,
	output logic                   data_ready_n,
	output logic      [WORD_W-1:0] ctrl_word,
	output logic      [WORD_W-1:0] wr_word,
	output logic                   wr_word_valid
);

	localparam int CW = $clog2(WORD_W + 1);
	localparam int DW = $clog2(SCLK_DIV);

	if (WORD_W < 2 || SCLK_DIV < 4 || SCLK_HI < 1 || SCLK_HI >= SCLK_DIV) begin : g_bad_param
		$error("asp_serial_port: WORD_W must be >= 2, SCLK_DIV >= 4, 0 < SCLK_HI < SCLK_DIV");
	end

	// ------------------------------------------------------------------
	// link side: clocked by the serial clock pin in both modes. in self
	// mode the pad returns our own driven clock, so one shifter serves both.
	// ------------------------------------------------------------------
	logic link_idle;
	logic link_rst;

	// shifters restart whenever both strobes are high; the clock may be
	// stopped then, so the clear cannot wait for an edge
	assign link_idle = receive_frame_strobe_n & transmit_frame_strobe_n;
	assign link_rst  = ~rst_n;

	logic [CW-1:0]     rx_cnt_q;
	logic [CW-1:0]     rx_cnt_d;
	logic [WORD_W-1:0] rx_sh_q;
	logic [WORD_W-1:0] rx_sh_d;
	logic              rx_done;
	logic [WORD_W-1:0] wr_hold_q;
	logic [WORD_W-1:0] wr_hold_d;
	logic              wr_sel_q;
	logic              wr_sel_d;
	logic              wr_tgl_q;
	logic              wr_tgl_d;

	// the count only advances on edges, so idle gaps between bit groups
	// simply leave it where it was
	always_comb begin
		rx_cnt_d  = rx_cnt_q;
		rx_sh_d   = rx_sh_q;
		rx_done   = 1'b0;
		wr_hold_d = wr_hold_q;
		wr_sel_d  = wr_sel_q;
		wr_tgl_d  = wr_tgl_q;
		if (!transmit_frame_strobe_n) begin
			rx_sh_d = {rx_sh_q[WORD_W-2:0], data_in};
			rx_done = (rx_cnt_q == CW'(WORD_W - 1));
			rx_cnt_d = rx_done ? '0 : CW'(rx_cnt_q + 1'b1);
		end
		if (rx_done) begin
			wr_hold_d = rx_sh_d;
			wr_sel_d  = register_select;
			wr_tgl_d  = ~wr_tgl_q;
		end
	end

	always_ff @(posedge sclk_i or posedge link_idle) begin
		if (link_idle) begin
			rx_cnt_q <= '0;
			rx_sh_q  <= '0;
		end else begin
			rx_cnt_q <= rx_cnt_d;
			rx_sh_q  <= rx_sh_d;
		end
	end

	always_ff @(posedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			wr_hold_q <= '0;
			wr_sel_q  <= 1'b0;
			wr_tgl_q  <= 1'b0;
		end else begin
			wr_hold_q <= wr_hold_d;
			wr_sel_q  <= wr_sel_d;
			wr_tgl_q  <= wr_tgl_d;
		end
	end

	logic [WORD_W-1:0] data_hold_q;
	logic [WORD_W-1:0] tx_word;
	logic [CW-1:0]     tx_cnt_q;
	logic [CW-1:0]     tx_cnt_d;
	logic              dout_d;
	logic              doe_d;
	logic              rd_done;
	logic              rd_sel_q;
	logic              rd_sel_d;
	logic              rd_tgl_q;
	logic              rd_tgl_d;

	// both words are held steady by the clk side while a read frame runs
	assign tx_word = register_select ? data_hold_q : ctrl_word;

	// bits leave on the falling edge so the host can take them on the rising
	always_comb begin
		tx_cnt_d = tx_cnt_q;
		dout_d   = data_out;
		doe_d    = 1'b0;
		rd_done  = 1'b0;
		rd_sel_d = rd_sel_q;
		rd_tgl_d = rd_tgl_q;
		if (!receive_frame_strobe_n && tx_cnt_q < CW'(WORD_W)) begin
			dout_d   = tx_word[CW'(WORD_W - 1) - tx_cnt_q];
			doe_d    = 1'b1;
			tx_cnt_d = CW'(tx_cnt_q + 1'b1);
			rd_done  = (tx_cnt_q == CW'(WORD_W - 1));
		end
		if (rd_done) begin
			rd_sel_d = register_select;
			rd_tgl_d = ~rd_tgl_q;
		end
	end

	always_ff @(negedge sclk_i or posedge link_idle) begin
		if (link_idle) begin
			tx_cnt_q    <= '0;
			data_out    <= 1'b0;
			data_out_oe <= 1'b0;
		end else begin
			tx_cnt_q    <= tx_cnt_d;
			data_out    <= dout_d;
			data_out_oe <= doe_d;
		end
	end

	always_ff @(negedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			rd_sel_q <= 1'b0;
			rd_tgl_q <= 1'b0;
		end else begin
			rd_sel_q <= rd_sel_d;
			rd_tgl_q <= rd_tgl_d;
		end
	end

	// ------------------------------------------------------------------
	// clk side: pin and toggle synchronisation
	// ------------------------------------------------------------------
	logic mode_s;
	logic rfs_s;
	logic tfs_s;
	logic rd_tgl_s;
	logic wr_tgl_s;

	asp_sync3 #(
		.W       (asp_pkg::SYNC_W),
		.RST_VAL (asp_pkg::SYNC_RST)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({clock_mode_self, receive_frame_strobe_n, transmit_frame_strobe_n, rd_tgl_q, wr_tgl_q}),
		.q     ({mode_s, rfs_s, tfs_s, rd_tgl_s, wr_tgl_s})
	);

	logic rd_tgl_p_q;
	logic wr_tgl_p_q;
	logic rd_evt;
	logic wr_evt;

	assign rd_evt = rd_tgl_s ^ rd_tgl_p_q;
	assign wr_evt = wr_tgl_s ^ wr_tgl_p_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_tgl_p_q <= 1'b0;
			wr_tgl_p_q <= 1'b0;
		end else begin
			rd_tgl_p_q <= rd_tgl_s;
			wr_tgl_p_q <= wr_tgl_s;
		end
	end

	// ------------------------------------------------------------------
	// self-clocking generator
	// ------------------------------------------------------------------
	asp_pkg::asp_gen_state_t state_q;
	asp_pkg::asp_gen_state_t state_d;
	logic [DW-1:0]           div_q;
	logic [DW-1:0]           div_d;
	logic [CW-1:0]           bits_q;
	logic [CW-1:0]           bits_d;
	logic                    sclk_o_d;
	logic                    sclk_oe_d;
	logic                    frame_off;

	assign frame_off = rfs_s & tfs_s;

	// the clock idles high so its first move after a strobe is a fall
	always_comb begin
		state_d   = state_q;
		div_d     = div_q;
		bits_d    = bits_q;
		sclk_o_d  = 1'b1;
		sclk_oe_d = 1'b0;
		unique case (state_q)
			asp_pkg::GEN_IDLE: begin
				if (mode_s && !frame_off) begin
					state_d   = asp_pkg::GEN_RUN;
					div_d     = '0;
					bits_d    = '0;
					sclk_o_d  = 1'b0;
					sclk_oe_d = 1'b1;
				end
			end
			asp_pkg::GEN_RUN: begin
				if (!mode_s || frame_off) begin
					state_d = asp_pkg::GEN_IDLE;
				end else if (div_q == DW'(SCLK_DIV - 1)) begin
					div_d  = '0;
					bits_d = CW'(bits_q + 1'b1);
					if (bits_q == CW'(WORD_W - 1)) begin
						state_d = asp_pkg::GEN_DONE;
					end else begin
						sclk_o_d  = 1'b0;
						sclk_oe_d = 1'b1;
					end
				end else begin
					div_d     = DW'(div_q + 1'b1);
					sclk_o_d  = (div_d >= DW'(SCLK_DIV - SCLK_HI));
					sclk_oe_d = 1'b1;
				end
			end
			asp_pkg::GEN_DONE: begin
				// one word per frame; the strobe must go high to rearm
				if (!mode_s || frame_off) begin
					state_d = asp_pkg::GEN_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= asp_pkg::GEN_IDLE;
			div_q   <= '0;
			bits_q  <= '0;
			sclk_o  <= 1'b1;
			sclk_oe <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q   <= div_d;
			bits_q  <= bits_d;
			sclk_o  <= sclk_o_d;
			sclk_oe <= sclk_oe_d;
		end
	end

	// ------------------------------------------------------------------
	// word holding: conversion result, control register, write results
	// ------------------------------------------------------------------
	logic [WORD_W-1:0] data_hold_d;
	logic              data_ready_n_d;
	logic [WORD_W-1:0] ctrl_d;
	logic [WORD_W-1:0] wr_word_d;
	logic              wr_valid_d;

	// a result arriving during a read frame is dropped: updating the held
	// word then would tear the word already on the wire
	always_comb begin
		data_hold_d = data_hold_q;
		data_ready_n_d      = data_ready_n;
		ctrl_d      = ctrl_word;
		wr_word_d   = wr_word;
		wr_valid_d  = 1'b0;
		if (rd_evt && rd_sel_q) begin
			data_ready_n_d = 1'b1;
		end
		if (conv_valid && rfs_s) begin
			data_hold_d = conv_word;
			data_ready_n_d      = 1'b0;
		end
		if (wr_evt) begin
			if (wr_sel_q) begin
				wr_word_d  = wr_hold_q;
				wr_valid_d = 1'b1;
			end else begin
				ctrl_d = wr_hold_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_hold_q   <= asp_pkg::DATA_RST;
			data_ready_n  <= 1'b1;
			ctrl_word     <= asp_pkg::CTRL_RST;
			wr_word       <= asp_pkg::DATA_RST;
			wr_word_valid <= 1'b0;
		end else begin
			data_hold_q   <= data_hold_d;
			data_ready_n  <= data_ready_n_d;
			ctrl_word     <= ctrl_d;
			wr_word       <= wr_word_d;
			wr_word_valid <= wr_valid_d;
		end
	end

endmodule

//--- rtl/asp_sync3.sv
// three-stage synchroniser; an output bit changes only once stages two and three agree
module asp_sync3 #(
	parameter int              W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] q_d;

	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q    <= q_d;
		end
	end

endmodule

//--- testbench/adc_serial_port_clocking_tb.sv
module adc_serial_port_clocking_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = asp_pkg::WORD_W;
	logic         clk;
	logic         rst_n;
	logic         mode;
	logic         conv_valid;
	logic [W-1:0] conv_word;
	logic [W-1:0] w;
	logic [W-1:0] r;
	wire          rx_n, tx_n, sel, hclk, din, so, soe, dout, rdy_n, doe, wv;
	wire  [W-1:0] ctrl, wr;
	wire          sclk_pin = soe ? so : hclk;
	int           seed = 32'h5EAC;
	int           failures = 0;
	int           compares = 0;
	int           cyc = 0;
	int           nw = 0;
	int           vcnt = 0;

	asp_serial_port dut_u (
		.clk(clk), .rst_n(rst_n), .clock_mode_self(mode), .receive_frame_strobe_n(rx_n),
		.transmit_frame_strobe_n(tx_n), .register_select(sel), .sclk_i(sclk_pin), .sclk_o(so),
		.sclk_oe(soe), .data_in(din), .data_out(dout), .data_out_oe(doe), .conv_word(conv_word),
		.conv_valid(conv_valid), .data_ready_n(rdy_n), .ctrl_word(ctrl), .wr_word(wr), .wr_word_valid(wv)
	);
	asp_host_model host_u (
		.clk(clk), .sclk_pin(sclk_pin), .dout(dout), .rx_n(rx_n), .tx_n(tx_n), .sel(sel), .sclk(hclk), .din(din)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input logic [W-1:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// conversion word offered for a given random word
	function automatic logic [W-1:0] conv_of(input logic [W-1:0] v);
		return v ^ 24'h5A5A5A;
	endfunction

	task automatic results;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wv)
			vcnt <= vcnt + 1;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end

	initial begin
		rst_n = 1'b0;
		mode = 1'b0;
		conv_valid = 1'b0;
		conv_word = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		check(ctrl, asp_pkg::CTRL_RST);
		check(W'(rdy_n), W'(1));
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			mode <= m[0];
			repeat (10) @(posedge clk);
			for (int k = 0; k < 2; k++) begin
				w = W'($random(seed));
				host_u.frame(m[0], 1'b0, 1'b0, w, W, k, r);
				check(ctrl, w);
				host_u.frame(m[0], 1'b1, 1'b0, '0, W, 0, r);
				check(r, w);
				check(W'(doe), '0);
				host_u.frame(m[0], 1'b0, 1'b1, ~w, W, k, r);
				check(wr, ~w);
				nw++;
				check(W'(vcnt), W'(nw));
				check(ctrl, w);
				// a word cut short by the strobe must leave no trace
				host_u.frame(m[0], 1'b0, 1'b1, w, 10, 0, r);
				check(wr, ~w);
				check(W'(vcnt), W'(nw));
				check(W'(soe), '0);
				@(posedge clk);
				conv_word <= conv_of(w);
				conv_valid <= 1'b1;
				@(posedge clk);
				conv_valid <= 1'b0;
				@(posedge clk);
				#1;
				check(W'(rdy_n), '0);
				host_u.frame(m[0], 1'b1, 1'b1, '0, W, k, r);
				check(r, conv_of(w));
				check(W'(rdy_n), W'(1));
			end
		end
		results();
	end
endmodule

//--- testbench/asp_host_model.sv
module asp_host_model (
	input wire logic clk,
	input wire logic sclk_pin,
	input wire logic dout,
	output logic     rx_n,
	output logic     tx_n,
	output logic     sel,
	output logic     sclk,
	output logic     din
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = asp_pkg::WORD_W;
	// clock parks high outside frames, standing in for the pin pull-up
	initial {rx_n, tx_n, sel, sclk, din} = 5'h1B;
	// half period of two 64 ns link ticks keeps the clock under clk / 5
	task automatic frame(input logic m, rd, s, input logic [W-1:0] w, input int n, gap, output logic [W-1:0] r);
		r = '0;
		@(posedge clk);
		sel <= s;
		@(posedge clk);
		if (rd)
			rx_n <= 1'b0;
		else
			tx_n <= 1'b0;
		// the self clock first falls about five clk after the strobe; waiting longer would miss it
		if (!m)
			repeat (6) @(posedge clk);
		for (int i = W - 1; i >= W - n; i--) begin
			if (m)
				@(negedge sclk_pin);
			else
				sclk = 1'b0;
			din = w[i];
			if (m)
				@(posedge sclk_pin);
			else
				#128 sclk = 1'b1;
			r[i] = dout;
			if (!m)
				#128;
			if (!m && gap != 0 && i % 8 == 0)
				#1000;
		end
		repeat (4) @(posedge clk);
		rx_n <= 1'b1;
		tx_n <= 1'b1;
		din  <= ~din;
		repeat (12) @(posedge clk);
	endtask
endmodule

//--- testbench/asp_serial_port_monitor.sv
module asp_monitor #(
	parameter int WORD_W = asp_pkg::WORD_W
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              clock_mode_self,
	input wire logic              receive_frame_strobe_n,
	input wire logic              transmit_frame_strobe_n,
	input wire logic              sclk_o,
	input wire logic              sclk_oe,
	input wire logic [WORD_W-1:0] ctrl_word,
	input wire logic              wr_word_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [5:0] bits_q;
	logic [5:0] bits_d;
	logic       o_q;
	wire        idle = receive_frame_strobe_n && transmit_frame_strobe_n;
	// counts falling serial clock edges while the pin is driven
	always_comb begin
		bits_d = bits_q;
		if (!sclk_oe)
			bits_d = '0;
		else if (o_q && !sclk_o)
			bits_d = bits_q + 6'h01;
	end
	always_ff @(posedge clk) begin
		bits_q <= rst_n ? bits_d : 6'h00;
		o_q    <= rst_n ? sclk_o : 1'b1;
	end
	a_start_clean: assert property ($rose(sclk_oe) |-> !sclk_o && clock_mode_self && !idle)
		else $error("clock drive began outside a frame");
	a_idle_high: assert property (!sclk_oe |-> sclk_o)
		else $error("undriven clock not parked high");
	a_release_idle: assert property (idle [*7] |-> !sclk_oe)
		else $error("clock still driven after frame end");
	a_word_len: assert property ($fell(sclk_oe) && !idle |-> bits_q == 6'(WORD_W))
		else $error("word ended on wrong bit count");
	a_ext_quiet: assert property (!clock_mode_self [*7] |-> !sclk_oe)
		else $error("clock driven in external mode");
	a_low_three: assert property ($fell(sclk_o) |-> ##1 (!sclk_o || !sclk_oe) ##1 (!sclk_o || !sclk_oe) ##1 sclk_o)
		else $error("serial low phase length wrong");
	a_high_one: assert property (sclk_oe && $rose(sclk_o) |=> !sclk_o || !sclk_oe)
		else $error("serial high phase length wrong");
	a_route_sel: assert property (wr_word_valid |-> $stable(ctrl_word))
		else $error("data write touched control");
	a_valid_pulse: assert property (wr_word_valid |=> !wr_word_valid)
		else $error("write strobe longer than one cycle");
	c_self_word: cover property ($fell(sclk_oe) && !idle);
	c_ctrl_load: cover property ($changed(ctrl_word));
	c_data_load: cover property (wr_word_valid);
endmodule

bind asp_serial_port asp_monitor #(.WORD_W(WORD_W)) mon_u (
	.clk(clk), .rst_n(rst_n), .clock_mode_self(clock_mode_self),
	.receive_frame_strobe_n(receive_frame_strobe_n), .transmit_frame_strobe_n(transmit_frame_strobe_n),
	.sclk_o(sclk_o), .sclk_oe(sclk_oe), .ctrl_word(ctrl_word), .wr_word_valid(wr_word_valid)
);
